// ### logic/bss_map.vh
// Constants of the bias supervisor sequencer: offsets, fields, states, times.
`ifndef BSS_MAP_VH
`define BSS_MAP_VH
// ==========================================================================
// Clock and time base
`define BSS_CLK_MHZ 100
`define BSS_TICK_US 1000
`define BSS_MS_CYCLES (`BSS_TICK_US * `BSS_CLK_MHZ)
`define BSS_OE_LOW_MS 5'd1
`define BSS_BIAS_TIMEOUT_MS 5'd15
`define BSS_LDO_OFF_MS 5'd5
// ==========================================================================
// Register byte offsets
`define BSS_REG_CTRL 4'h0
`define BSS_REG_STATUS0 4'h4
`define BSS_REG_STATUS1 4'h8
`define BSS_REG_STATE 4'hc
`define BSS_CTRL_RESET 1'b0
// ==========================================================================
// Synchronised input vector positions
`define BSS_IN_PUMP_LOW 0
`define BSS_IN_BYPASS 1
`define BSS_IN_UV 2
`define BSS_IN_OV 3
`define BSS_IN_SEVERE 4
`define BSS_IN_RELEASE 5
`define BSS_IN_LDO_UV 6
`define BSS_IN_HOT 7
`define BSS_IN_WARN 8
`define BSS_IN_READY 9
`define BSS_IN_OE 10
`define BSS_IN_WAKE 11
`define BSS_IN_FAULT_PIN 12
`define BSS_IN_WIDTH 13
// ==========================================================================
// Message pending bits and link codes
`define BSS_MSG_OT 0
`define BSS_MSG_UV 1
`define BSS_MSG_OV 2
`define BSS_MSG_LDO 3
`define BSS_MSG_WARN 4
`define BSS_CODE_OT 16'h8504
`define BSS_CODE_UV 16'h8508
`define BSS_CODE_OV 16'h8510
`define BSS_CODE_LDO 16'h8601
`define BSS_CODE_WARN 16'h8502
// ==========================================================================
// Sequencer states
`define BSS_ST_POR 3'h0
`define BSS_ST_LDO_UP 3'h1
`define BSS_ST_STANDBY 3'h2
`define BSS_ST_BIAS 3'h3
`define BSS_ST_ACTIVE 3'h4
`define BSS_ST_SLEEP 3'h5
`define BSS_ST_SHDN 3'h6
`define BSS_ST_OT 3'h7
`endif

// ### logic/bss_sync.v
// Three-stage input synchroniser that accepts a change once stages agree.
`timescale 1ns/100ps
`default_nettype none
module bss_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar i;
  // ========================================================================
  // Per-bit chain
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // First stage feeds only the second; output moves when two and three agree.
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          s1[i] <= d[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            q[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule // bss_sync
`default_nettype wire

// ### logic/bss_top.v
// Supervisor and sequencer for the gate-bias generator with AHB-Lite access.
`timescale 1ns/100ps
`default_nettype none
`include "bss_map.vh"
module bss_top #(
  parameter integer MS_CYCLES = `BSS_MS_CYCLES
) (
  input wire SYS_CLK,
  input wire NRST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output reg [31:0] HRDATA,
  input wire VDD_BELOW_PUMP,
  input wire VDD_ABOVE_BYPASS,
  input wire VDD_UV,
  input wire VDD_OV,
  input wire VDD_SEVERE_UV,
  input wire VDD_ABOVE_RELEASE,
  input wire LDO_UV,
  input wire TEMP_HOT,
  input wire TEMP_WARN,
  input wire BIAS_READY,
  input wire OE,
  input wire WAKE,
  input wire FAULT_PIN_I,
  output wire FAULT_PIN_O,
  output reg FAULT_PIN_OE,
  output reg PUMP_EN,
  output reg PUMP_BYPASS,
  output reg BIAS_EN,
  output reg DRIVER_EN,
  output reg LDO_EN,
  output reg LDO_PULLDOWN,
  output reg LINK_EN,
  output reg LINK_MSG_REQ,
  output reg [15:0] LINK_MSG_CODE,
  input wire LINK_MSG_ACK
);
  localparam [31:0] MS_LAST_FULL = MS_CYCLES - 1;
  localparam [16:0] MS_LAST = MS_LAST_FULL[16:0];
  wire [`BSS_IN_WIDTH-1:0] raw_in;
  wire [`BSS_IN_WIDTH-1:0] in;
  reg [2:0] state;
  reg [2:0] next_state;
  reg oe_d;
  reg wake_d;
  reg sleep_cfg;
  reg f_ot;
  reg f_uv;
  reg f_ov;
  reg f_ldo;
  reg f_shdn;
  reg w_temp;
  reg ldo_uv_off;
  reg ot_sent;
  reg [4:0] pend;
  reg [4:0] next_pend;
  reg [4:0] new_ev;
  reg [16:0] cyc;
  reg [4:0] ms;
  reg tmr_clr;
  reg [15:0] code;
  reg [2:0] pick;
  reg any_pend;
  reg a_write;
  reg [3:0] a_off;
  reg [31:0] rd;
  integer k;
  wire oe_rise;
  wire fault_any;
  wire lockout;
  wire a_valid;

  assign raw_in = {FAULT_PIN_I, WAKE, OE, BIAS_READY, TEMP_WARN, TEMP_HOT,
                   LDO_UV, VDD_ABOVE_RELEASE, VDD_SEVERE_UV, VDD_OV, VDD_UV,
                   VDD_ABOVE_BYPASS, VDD_BELOW_PUMP};
  bss_sync #(.W(`BSS_IN_WIDTH)) u_sync (
    .clk(SYS_CLK),
    .nrst(NRST),
    .d(raw_in),
    .q(in)
  );

  // ========================================================================
  // Edge detection and combined conditions
  assign oe_rise = in[`BSS_IN_OE] & ~oe_d;
  assign fault_any = f_ot | f_uv | f_ov | f_ldo | f_shdn;
  assign lockout = in[`BSS_IN_UV] | in[`BSS_IN_OV] | in[`BSS_IN_LDO_UV];
  assign FAULT_PIN_O = 1'b0;

  // Previous levels of OE and WAKE for edge detection.
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      oe_d <= 1'b0;
      wake_d <= 1'b0;
    end else begin
      oe_d <= in[`BSS_IN_OE];
      wake_d <= in[`BSS_IN_WAKE];
    end
  end

  // ========================================================================
  // Fault latches; a new cause wins over a clear in the same cycle
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      f_ot <= 1'b0;
      f_uv <= 1'b0;
      f_ov <= 1'b0;
      f_ldo <= 1'b0;
      f_shdn <= 1'b0;
      w_temp <= 1'b0;
    end else begin
      f_ot <= in[`BSS_IN_HOT] | (f_ot & ~oe_rise);
      f_uv <= in[`BSS_IN_UV] | (f_uv & ~oe_rise);
      f_ov <= in[`BSS_IN_OV] | (f_ov & ~oe_rise);
      f_ldo <= in[`BSS_IN_LDO_UV] | (f_ldo & ~oe_rise);
      f_shdn <= in[`BSS_IN_SEVERE] | (f_shdn & ~oe_rise);
      w_temp <= in[`BSS_IN_WARN] | (w_temp & ~oe_rise);
    end
  end

  // ========================================================================
  // Millisecond timer; one-cycle tick resets the cycle count
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cyc <= 17'h00000;
      ms <= 5'h00;
    end else if (tmr_clr) begin
      cyc <= 17'h00000;
      ms <= 5'h00;
    end else if (cyc == MS_LAST) begin
      cyc <= 17'h00000;
      if (ms != 5'h1f) begin
        ms <= ms + 5'h01;
      end
    end else begin
      cyc <= cyc + 17'h00001;
    end
  end

  // ========================================================================
  // Sequencer next state and timer restart
  always @* begin
    next_state = state;
    tmr_clr = 1'b0;
    case (state)
      `BSS_ST_POR: begin
        if (!in[`BSS_IN_SEVERE]) begin
          next_state = `BSS_ST_LDO_UP;
        end
      end
      `BSS_ST_LDO_UP: begin
        if (!in[`BSS_IN_LDO_UV] && !ldo_uv_off) begin
          next_state = `BSS_ST_STANDBY;
        end
      end
      `BSS_ST_STANDBY: begin
        if (in[`BSS_IN_OE]) begin
          next_state = `BSS_ST_BIAS;
        end
      end
      `BSS_ST_BIAS: begin
        if (in[`BSS_IN_READY] || ms >= `BSS_BIAS_TIMEOUT_MS) begin
          next_state = `BSS_ST_ACTIVE;
        end
      end
      `BSS_ST_ACTIVE: begin
        tmr_clr = in[`BSS_IN_OE];
        if (!in[`BSS_IN_OE] && ms >= `BSS_OE_LOW_MS) begin
          next_state = sleep_cfg ? `BSS_ST_SLEEP : `BSS_ST_STANDBY;
        end
      end
      `BSS_ST_SLEEP: begin
        if (in[`BSS_IN_WAKE] && !wake_d) begin
          next_state = `BSS_ST_POR;
        end
      end
      `BSS_ST_SHDN: begin
        if (in[`BSS_IN_RELEASE] && !in[`BSS_IN_SEVERE]) begin
          next_state = `BSS_ST_POR;
        end
      end
      `BSS_ST_OT: begin
        tmr_clr = ~ot_sent;
        if (!in[`BSS_IN_HOT] && oe_rise) begin
          next_state = `BSS_ST_LDO_UP;
        end
      end
      default: begin
        next_state = `BSS_ST_POR;
      end
    endcase
    if (in[`BSS_IN_SEVERE] && state != `BSS_ST_SHDN &&
        state != `BSS_ST_POR) begin
      next_state = `BSS_ST_SHDN;
    end else if (in[`BSS_IN_HOT] && state != `BSS_ST_OT &&
                 state != `BSS_ST_SHDN && state != `BSS_ST_SLEEP) begin
      next_state = `BSS_ST_OT;
    end
    if (next_state != state) begin
      tmr_clr = 1'b1;
    end
  end

  // State register, LDO lockout latch and overtemperature message flag.
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= `BSS_ST_POR;
      ldo_uv_off <= 1'b0;
      ot_sent <= 1'b0;
    end else begin
      state <= next_state;
      if (in[`BSS_IN_UV]) begin
        ldo_uv_off <= 1'b1;
      end else if (in[`BSS_IN_RELEASE]) begin
        ldo_uv_off <= 1'b0;
      end
      if (state != `BSS_ST_OT) begin
        ot_sent <= 1'b0;
      end else if (LINK_MSG_REQ && LINK_MSG_ACK &&
                   LINK_MSG_CODE == `BSS_CODE_OT) begin
        ot_sent <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Message queue: one pending bit per source, lowest index first
  always @* begin
    new_ev = 5'h00;
    new_ev[`BSS_MSG_OT] = in[`BSS_IN_HOT] & ~f_ot;
    new_ev[`BSS_MSG_UV] = in[`BSS_IN_UV] & ~f_uv;
    new_ev[`BSS_MSG_OV] = in[`BSS_IN_OV] & ~f_ov;
    new_ev[`BSS_MSG_LDO] = in[`BSS_IN_LDO_UV] & ~f_ldo;
    new_ev[`BSS_MSG_WARN] = in[`BSS_IN_WARN] & ~w_temp;
    pick = 3'h0;
    any_pend = 1'b0;
    for (k = 4; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        pick = k[2:0];
        any_pend = 1'b1;
      end
    end
    case (pick)
      3'h0: code = `BSS_CODE_OT;
      3'h1: code = `BSS_CODE_UV;
      3'h2: code = `BSS_CODE_OV;
      3'h3: code = `BSS_CODE_LDO;
      default: code = `BSS_CODE_WARN;
    endcase
    next_pend = pend;
    // Clear the source whose code went out; pick may have moved since.
    if (LINK_MSG_REQ && LINK_MSG_ACK) begin
      case (LINK_MSG_CODE)
        `BSS_CODE_OT: next_pend[`BSS_MSG_OT] = 1'b0;
        `BSS_CODE_UV: next_pend[`BSS_MSG_UV] = 1'b0;
        `BSS_CODE_OV: next_pend[`BSS_MSG_OV] = 1'b0;
        `BSS_CODE_LDO: next_pend[`BSS_MSG_LDO] = 1'b0;
        default: next_pend[`BSS_MSG_WARN] = 1'b0;
      endcase
    end
    next_pend = next_pend | new_ev;
    if (!LINK_EN) begin
      next_pend = 5'h00;
    end
  end

  // Request stays up with a stable code until the link acknowledges it.
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pend <= 5'h00;
      LINK_MSG_REQ <= 1'b0;
      LINK_MSG_CODE <= 16'h0000;
    end else begin
      pend <= next_pend;
      if (LINK_MSG_REQ && !LINK_MSG_ACK) begin
        LINK_MSG_REQ <= 1'b1;
      end else begin
        LINK_MSG_REQ <= any_pend & LINK_EN & ~(LINK_MSG_REQ & LINK_MSG_ACK);
        LINK_MSG_CODE <= code;
      end
    end
  end

  // ========================================================================
  // Block enables derived from state and faults
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      PUMP_EN <= 1'b0;
      PUMP_BYPASS <= 1'b0;
      BIAS_EN <= 1'b0;
      DRIVER_EN <= 1'b0;
      LDO_EN <= 1'b0;
      LDO_PULLDOWN <= 1'b0;
      LINK_EN <= 1'b0;
      FAULT_PIN_OE <= 1'b1;
    end else begin
      // bias only while starting or active
      BIAS_EN <= (state == `BSS_ST_BIAS || state == `BSS_ST_ACTIVE) &
                 ~lockout;
      PUMP_EN <= (state == `BSS_ST_BIAS || state == `BSS_ST_ACTIVE) &
                 ~lockout & in[`BSS_IN_PUMP_LOW] & ~in[`BSS_IN_BYPASS];
      PUMP_BYPASS <= in[`BSS_IN_BYPASS];
      DRIVER_EN <= (state == `BSS_ST_ACTIVE) & ~fault_any & ~lockout;
      LDO_EN <= ~ldo_uv_off & ~in[`BSS_IN_SEVERE] &
                (state != `BSS_ST_POR) & (state != `BSS_ST_SLEEP) &
                (state != `BSS_ST_SHDN) &
                ~((state == `BSS_ST_OT) & ot_sent &
                  (ms >= `BSS_LDO_OFF_MS));
      LDO_PULLDOWN <= (state == `BSS_ST_SLEEP) | (state == `BSS_ST_SHDN);
      // messaging off after sent with OE low
      LINK_EN <= (state != `BSS_ST_POR) & (state != `BSS_ST_SLEEP) &
                 (state != `BSS_ST_SHDN) &
                 ~((state == `BSS_ST_OT) & ot_sent & ~in[`BSS_IN_OE]);
      FAULT_PIN_OE <= fault_any | (state == `BSS_ST_POR) |
                      (state == `BSS_ST_LDO_UP);
    end
  end

  // ========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign a_valid = HSEL & HTRANS[1] & HREADY;

  // Read mux for the address phase; unmapped offsets read zero.
  always @* begin
    rd = 32'h00000000;
    case (HADDR[3:0])
      `BSS_REG_CTRL: rd[0] = sleep_cfg;
      `BSS_REG_STATUS0: rd[4:0] = {f_ov, f_uv, f_ot, w_temp, fault_any};
      `BSS_REG_STATUS1: rd[1:0] = {f_shdn, f_ldo};
      `BSS_REG_STATE: rd[5:0] = {in[`BSS_IN_FAULT_PIN], LINK_EN, DRIVER_EN,
                                 state};
      default: rd = 32'h00000000;
    endcase
    if (HADDR[31:4] != 28'h0000000) begin
      rd = 32'h00000000;
    end
  end

  // Address phase capture, write data phase and registered read data.
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      a_write <= 1'b0;
      a_off <= 4'h0;
      sleep_cfg <= `BSS_CTRL_RESET;
      HRDATA <= 32'h00000000;
    end else begin
      a_write <= a_valid & HWRITE & (HADDR[31:4] == 28'h0000000);
      a_off <= HADDR[3:0];
      if (a_valid && !HWRITE) begin
        HRDATA <= rd;
      end
      if (a_write && a_off == `BSS_REG_CTRL) begin
        sleep_cfg <= HWDATA[0];
      end
    end
  end
endmodule // bss_top
`default_nettype wire

// ### testbench/bss_top_assertions.sv
// Concurrent checks on the ports of the bias supervisor sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "bss_map.vh"
module bss_top_assertions #(
  parameter integer MS_CYCLES = 20
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic VDD_UV,
  input wire logic VDD_SEVERE_UV,
  input wire logic PUMP_EN,
  input wire logic PUMP_BYPASS,
  input wire logic BIAS_EN,
  input wire logic DRIVER_EN,
  input wire logic LDO_EN,
  input wire logic LDO_PULLDOWN,
  input wire logic FAULT_PIN_OE,
  input wire logic LINK_EN,
  input wire logic LINK_MSG_REQ,
  input wire logic [15:0] LINK_MSG_CODE,
  input wire logic LINK_MSG_ACK
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // ==========================================================================
  // Startup wait counter
  logic [31:0] bias_wait;
  // Counts cycles with the bias regulator on while drivers are still off.
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      bias_wait <= 32'h0;
    end else if (BIAS_EN && !DRIVER_EN) begin
      bias_wait <= bias_wait + 32'h1;
    end else begin
      bias_wait <= 32'h0;
    end
  end
  // ==========================================================================
  // Properties
  // startup timeout bound
  a_bias_timeout: assert property (
    bias_wait <= 15 * MS_CYCLES + 4) else $error("bias startup too long");
  a_bus_okay: assert property (
    HREADYOUT && !HRESP) else $error("bus answer not ready okay");
  a_req_holds: assert property (
    LINK_MSG_REQ && !LINK_MSG_ACK |=>
    (LINK_MSG_REQ && $stable(LINK_MSG_CODE)) || !LINK_EN)
    else $error("message request dropped early");
  a_req_drops: assert property (
    LINK_MSG_REQ && LINK_MSG_ACK |=> !LINK_MSG_REQ)
    else $error("message request held after ack");
  a_bypass_pump: assert property (
    PUMP_BYPASS |-> !PUMP_EN) else $error("pump on while bypassed");
  a_driver_bias: assert property (
    DRIVER_EN |-> BIAS_EN) else $error("drivers on without bias");
  a_pulldown_ldo: assert property (
    LDO_PULLDOWN |-> !LDO_EN) else $error("pull-down on with LDO on");
  a_uv_lockout: assert property (
    VDD_UV [*8] |-> !PUMP_EN && !BIAS_EN && !DRIVER_EN && !LDO_EN)
    else $error("lockout left a supply on");
  a_uv_fault_pin: assert property (
    $rose(VDD_UV) |-> ##[1:8] FAULT_PIN_OE) else $error("no fault pin");
  a_severe_off: assert property (
    VDD_SEVERE_UV [*8] |-> !LDO_EN && LDO_PULLDOWN && !BIAS_EN)
    else $error("severe undervoltage left LDO on");
endmodule // bss_top_assertions
bind bss_top bss_top_assertions #(.MS_CYCLES(MS_CYCLES))
  bss_top_assertions_inst (.SYS_CLK, .NRST, .HREADYOUT, .HRESP, .VDD_UV,
  .VDD_SEVERE_UV, .PUMP_EN, .PUMP_BYPASS, .BIAS_EN, .DRIVER_EN, .LDO_EN,
  .LDO_PULLDOWN, .FAULT_PIN_OE, .LINK_EN, .LINK_MSG_REQ, .LINK_MSG_CODE,
  .LINK_MSG_ACK);
`default_nettype wire

// ### testbench/bss_link_host.sv
// Host-side link transmitter model that acknowledges message requests.
`timescale 1ns/100ps
`default_nettype none
module bss_link_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic req,
  input wire logic [15:0] code,
  output logic ack,
  output logic [15:0] last_code,
  output logic [7:0] msg_count
);
  logic [3:0] busy;
  // message receipt
  // A request is sent after one cycle, or six when slow, then acked once.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 4'h0;
      ack <= 1'b0;
      last_code <= 16'h0;
      msg_count <= 8'h0;
    end else if (req && !ack && busy >= (slow ? 4'h6 : 4'h1)) begin
      ack <= 1'b1;
      last_code <= code;
      msg_count <= msg_count + 8'h1;
      busy <= 4'h0;
    end else begin
      ack <= 1'b0;
      busy <= (req && !ack) ? busy + 4'h1 : 4'h0;
    end
  end
endmodule // bss_link_host
`default_nettype wire

// ### testbench/bss_top_tb.sv
// Self-checking bench for the bias supervisor sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "bss_map.vh"
module bss_top_tb;
  logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic vdd_lo = 1'b0, vdd_byp = 1'b0, vdd_uv = 1'b0, vdd_ov = 1'b0;
  logic vdd_sev = 1'b0, vdd_rel = 1'b1, ldo_uv = 1'b0, hot = 1'b0;
  logic warn = 1'b0, ready = 1'b0, oe = 1'b0, wake = 1'b0, slow = 1'b0;
  wire logic hreadyout, hresp, fpin_o, fpin_oe, pump_en, pump_byp, bias_en;
  wire logic drv_en, ldo_en, ldo_pd, link_en, req, ack;
  wire logic [31:0] hrdata;
  wire logic [15:0] code, last_code;
  wire logic [7:0] msg_count;
  // Open-drain fault pin with its external pull-up.
  wire logic fpin = fpin_oe ? fpin_o : 1'b1;
  int failures = 0, num_checks = 0, cycles = 0;
  bss_top #(.MS_CYCLES(20)) bss_top_inst (.SYS_CLK(sys_clk), .NRST(nrst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
    .VDD_BELOW_PUMP(vdd_lo), .VDD_ABOVE_BYPASS(vdd_byp), .VDD_UV(vdd_uv),
    .VDD_OV(vdd_ov), .VDD_SEVERE_UV(vdd_sev), .VDD_ABOVE_RELEASE(vdd_rel),
    .LDO_UV(ldo_uv), .TEMP_HOT(hot), .TEMP_WARN(warn), .BIAS_READY(ready),
    .OE(oe), .WAKE(wake), .FAULT_PIN_I(fpin), .FAULT_PIN_O(fpin_o),
    .FAULT_PIN_OE(fpin_oe), .PUMP_EN(pump_en), .PUMP_BYPASS(pump_byp),
    .BIAS_EN(bias_en), .DRIVER_EN(drv_en), .LDO_EN(ldo_en),
    .LDO_PULLDOWN(ldo_pd), .LINK_EN(link_en), .LINK_MSG_REQ(req),
    .LINK_MSG_CODE(code), .LINK_MSG_ACK(ack));
  bss_link_host bss_link_host_inst (.clk(sys_clk), .nrst(nrst),
    .slow(slow), .req(req), .code(code), .ack(ack),
    .last_code(last_code), .msg_count(msg_count));
  // ==========================================================================
  // Clock, hang limit and tasks
  // Free-running 100 MHz clock.
  always #5 sys_clk = ~sys_clk;
  // Cuts a hung run short and counts it as a failure.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One single-word transfer; read data is taken at the data phase edge.
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rdv = hrdata;
    #1;
  endtask
  task rd(input logic [3:0] o);
    xfer(1'b0, {28'h0, o}, 32'h0);
  endtask
  task wr(input logic [3:0] o, input logic [31:0] d);
    xfer(1'b1, {28'h0, o}, d);
  endtask
  task wst(input logic [2:0] s);
    int i;
    rdv = 32'hx;
    for (i = 0; i < 250 && rdv[2:0] !== s; i++) rd(`BSS_REG_STATE);
    chk("state", s, rdv[2:0]);
  endtask
  task tog();
    oe <= 1'b0;
    cyc(5);
    oe <= 1'b1;
    cyc(10);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    wst(`BSS_ST_STANDBY);
    rd(`BSS_REG_CTRL);
    chk("ctrl", 32'h0, rdv);
    xfer(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rdv);
    oe <= 1'b1;
    wst(`BSS_ST_BIAS);
    cyc(250);
    rd(`BSS_REG_STATE);
    chk("state", `BSS_ST_BIAS, rdv[2:0]);
    chk("driver en", 1'b0, drv_en);
    wst(`BSS_ST_ACTIVE);
    vdd_lo <= 1'b1;
    cyc(8);
    chk("pump en", 1'b1, pump_en);
    vdd_lo <= 1'b0;
    vdd_byp <= 1'b1;
    cyc(8);
    chk("pump en", 1'b0, pump_en);
    chk("bypass", 1'b1, pump_byp);
    vdd_byp <= 1'b0;
    slow <= 1'b1;
    warn <= 1'b1;
    cyc(20);
    chk("code", `BSS_CODE_WARN, last_code);
    chk("driver en", 1'b1, drv_en);
    chk("fault pin", 1'b0, fpin_oe);
    rd(`BSS_REG_STATE);
    chk("fault level", 1'b1, rdv[5]);
    vdd_uv <= 1'b1;
    vdd_rel <= 1'b0;
    cyc(20);
    chk("code", `BSS_CODE_UV, last_code);
    chk("fault pin", 1'b1, fpin_oe);
    rd(`BSS_REG_STATE);
    chk("fault level", 1'b0, rdv[5]);
    tog();
    rd(`BSS_REG_STATUS0);
    chk("status0", 32'hb, rdv);
    chk("messages", 8'h2, msg_count);
    vdd_uv <= 1'b0;
    vdd_rel <= 1'b1;
    warn <= 1'b0;
    cyc(8);
    tog();
    wr(`BSS_REG_STATUS0, 32'hffffffff);
    rd(`BSS_REG_STATUS0);
    chk("status0", 32'h0, rdv);
    chk("ldo en", 1'b1, ldo_en);
    slow <= 1'b0;
    ldo_uv <= 1'b1;
    cyc(20);
    chk("code", `BSS_CODE_LDO, last_code);
    chk("ldo en", 1'b1, ldo_en);
    rd(`BSS_REG_STATUS1);
    chk("status1", 32'h1, rdv);
    ldo_uv <= 1'b0;
    vdd_ov <= 1'b1;
    cyc(20);
    chk("code", `BSS_CODE_OV, last_code);
    chk("driver en", 1'b0, drv_en);
    vdd_ov <= 1'b0;
    ready <= 1'b1;
    cyc(8);
    tog();
    wst(`BSS_ST_ACTIVE);
    hot <= 1'b1;
    cyc(20);
    chk("code", `BSS_CODE_OT, last_code);
    chk("bias en", 1'b0, bias_en);
    chk("ldo en", 1'b1, ldo_en);
    chk("link en", 1'b1, link_en);
    oe <= 1'b0;
    cyc(10);
    chk("link en", 1'b0, link_en);
    oe <= 1'b1;
    cyc(10);
    rd(`BSS_REG_STATE);
    chk("state", `BSS_ST_OT, rdv[2:0]);
    oe <= 1'b0;
    hot <= 1'b0;
    cyc(100);
    chk("ldo en", 1'b0, ldo_en);
    oe <= 1'b1;
    wst(`BSS_ST_ACTIVE);
    wr(`BSS_REG_CTRL, 32'h1);
    oe <= 1'b0;
    cyc(8);
    rd(`BSS_REG_STATE);
    chk("state", `BSS_ST_ACTIVE, rdv[2:0]);
    wst(`BSS_ST_SLEEP);
    chk("ldo pull", 1'b1, ldo_pd);
    chk("bias en", 1'b0, bias_en);
    wake <= 1'b1;
    wst(`BSS_ST_STANDBY);
    wake <= 1'b0;
    wr(`BSS_REG_CTRL, 32'h0);
    oe <= 1'b1;
    cyc(30);
    rd(`BSS_REG_STATE);
    chk("state", `BSS_ST_ACTIVE, rdv[2:0]);
    wst(`BSS_ST_ACTIVE);
    oe <= 1'b0;
    wst(`BSS_ST_STANDBY);
    chk("bias en", 1'b0, bias_en);
    vdd_sev <= 1'b1;
    vdd_rel <= 1'b0;
    cyc(12);
    vdd_sev <= 1'b0;
    cyc(10);
    rd(`BSS_REG_STATE);
    chk("state", `BSS_ST_SHDN, rdv[2:0]);
    chk("ldo pull", 1'b1, ldo_pd);
    vdd_rel <= 1'b1;
    wst(`BSS_ST_STANDBY);
    end_of_test();
  end
endmodule // bss_top_tb
`default_nettype wire
